// *** core/ifd_pkg.sv ***
// Package with instruction field layouts, opcode classes and timing constants for the decoder.
package ifd_pkg;

    localparam int WORD_W     = 14;
    localparam int SLOT_W     = 7;
    localparam int BITPOS_W   = 3;
    localparam int LIT8_W     = 8;
    localparam int LIT11_W    = 11;
    localparam int OSC_PER_CYC = 4;

    // Field positions within the instruction word.
    localparam int CLS_HI     = 13;
    localparam int CLS_LO     = 12;
    localparam int OP4_HI     = 11;
    localparam int OP4_LO     = 8;
    localparam int DEST_BIT   = 7;
    localparam int BITOP_HI   = 11;
    localparam int BITOP_LO   = 10;
    localparam int BITPOS_HI  = 9;
    localparam int BITPOS_LO  = 7;
    localparam int JMP_SEL    = 11;

    localparam logic [1:0] CLS_BYTE  = 2'h0;
    localparam logic [1:0] CLS_BIT   = 2'h1;
    localparam logic [1:0] CLS_JUMP  = 2'h2;
    localparam logic [1:0] CLS_LIT   = 2'h3;

    localparam logic [1:0] BITOP_CLR = 2'h0;
    localparam logic [1:0] BITOP_SET = 2'h1;
    localparam logic [1:0] BITOP_SKL = 2'h2;
    localparam logic [1:0] BITOP_SKH = 2'h3;

    localparam logic [3:0] OP_DECFSZ = 4'hb;
    localparam logic [3:0] OP_INCFSZ = 4'hf;
    localparam logic [3:0] OP_MISC   = 4'h0;
    localparam logic [3:0] LIT_RET   = 4'h4;
    localparam logic [3:0] LIT_RETM  = 4'hc;

    localparam logic [13:0] WATCHDOG_CLEAR_OP = 14'h0064;
    localparam logic [13:0] SLEEP_OP          = 14'h0063;
    localparam logic [13:0] RETURN_OP         = 14'h0008;
    localparam logic [13:0] RETFIE_OP         = 14'h0009;
    localparam logic [13:0] IDLE_MASK         = 14'h3f9f;
    localparam logic [13:0] IDLE_OP           = 14'h0000;

    typedef enum logic [1:0] {
        IFD_BYTE_OPS = 2'b00,
        IFD_BIT_OPS  = 2'b01,
        IFD_LIT_CTRL = 2'b10
    } ifd_class_t;

    typedef struct packed {
        ifd_class_t        cls;
        logic [5:0]        opcode;
        logic [6:0]        reg_slot;
        logic              dest_reg;
        logic              acc_write;
        logic              reg_write;
        logic [2:0]        bit_pos;
        logic [7:0]        bit_mask;
        logic [1:0]        bit_op;
        logic [7:0]        lit8;
        logic [10:0]       lit11;
        logic              is_jump;
        logic              is_cond;
        logic              is_ret;
        logic              watchdog_clear_op;
        logic              sleep_op;
        logic              idle_op;
    } ifd_fields_t;

endpackage

// *** core/ifd_cycle_gen.sv ***
// Divides the oscillator into four phases that form one instruction cycle.
`timescale 1ns/1ns
module ifd_cycle_gen #(
    parameter int PHASES = ifd_pkg::OSC_PER_CYC
) (
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_rst_n,
    // Phase outputs
    output logic [1:0] o_phase,
    output logic       o_cycle_end
);

    logic [1:0] phase;
    logic [1:0] next_phase;

    always_comb begin
        if (phase == 2'(PHASES - 1)) begin
            next_phase = 2'h0;
        end else begin
            next_phase = phase + 2'h1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            phase <= 2'h0;
        end else begin
            phase <= next_phase;
        end
    end

    assign o_phase     = phase;
    assign o_cycle_end = (phase == 2'(PHASES - 1));

    a_cycle_four_osc: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_cycle_end |=> !o_cycle_end [*3] ##1 o_cycle_end)
        else $error("instruction cycle is not four oscillator periods");

endmodule // ifd_cycle_gen

// *** core/ifd_decoder.sv ***
// Instruction format decoder: splits 14-bit words into fields and sequences cycle counts.
`timescale 1ns/1ns
module ifd_decoder (
    // Clock and reset
    input  wire logic                    i_core_clk,
    input  wire logic                    i_rst_n,
    // Program memory word, sampled at the end of each instruction cycle except the first cycle of a two-cycle instruction
    input  wire logic [13:0]             i_instr_word,
    // Outcome of the conditional test of the current instruction
    input  wire logic                    i_test_true,
    // Decoded fields and sequencing
    output ifd_pkg::ifd_fields_t         o_fields,
    output logic                         o_flush_cycle,
    output logic [1:0]                   o_phase,
    output logic                         o_cycle_end,
    output logic                         o_fetch
);

    typedef enum logic [0:0] {
        IFD_EXEC  = 1'b0,
        IFD_FLUSH = 1'b1
    } ifd_state_t;

    ifd_pkg::ifd_fields_t dec;
    ifd_pkg::ifd_fields_t fields;
    ifd_pkg::ifd_fields_t next_fields;
    ifd_state_t           state;
    ifd_state_t           next_state;
    logic                 cycle_end;
    logic [1:0]           cls_bits;
    logic                 two_cycle;

    ifd_cycle_gen #(
        .PHASES(ifd_pkg::OSC_PER_CYC)
    ) u_cycle (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .o_phase    (o_phase),
        .o_cycle_end(cycle_end)
    );

    assign cls_bits = i_instr_word[ifd_pkg::CLS_HI:ifd_pkg::CLS_LO];

    always_comb begin
        dec          = '0;
        dec.opcode   = i_instr_word[ifd_pkg::CLS_HI:ifd_pkg::OP4_LO];
        dec.reg_slot = i_instr_word[ifd_pkg::SLOT_W-1:0];
        dec.bit_pos  = i_instr_word[ifd_pkg::BITPOS_HI:ifd_pkg::BITPOS_LO];
        dec.bit_mask = 8'h01 << dec.bit_pos;
        dec.lit8     = i_instr_word[ifd_pkg::LIT8_W-1:0];
        dec.lit11    = i_instr_word[ifd_pkg::LIT11_W-1:0];
        case (cls_bits)
            ifd_pkg::CLS_BYTE: begin
                dec.cls = ifd_pkg::IFD_BYTE_OPS;
            end
            ifd_pkg::CLS_BIT: begin
                dec.cls = ifd_pkg::IFD_BIT_OPS;
            end
            default: begin
                dec.cls = ifd_pkg::IFD_LIT_CTRL;
            end
        endcase
        dec.watchdog_clear_op = (i_instr_word == ifd_pkg::WATCHDOG_CLEAR_OP);
        dec.sleep_op = (i_instr_word == ifd_pkg::SLEEP_OP);
        // Masked compare treats the two ignored bits of the idle word as either value.
        dec.idle_op = ((i_instr_word & ifd_pkg::IDLE_MASK) == ifd_pkg::IDLE_OP);
        dec.is_ret = (i_instr_word == ifd_pkg::RETURN_OP) || (i_instr_word == ifd_pkg::RETFIE_OP);
        if (dec.cls == ifd_pkg::IFD_BYTE_OPS) begin
            dec.dest_reg = i_instr_word[ifd_pkg::DEST_BIT];
            // Only opcodes with a real destination bit may write the accumulator; misc words write the register when the destination bit is set.
            if (i_instr_word[ifd_pkg::OP4_HI:ifd_pkg::OP4_LO] != ifd_pkg::OP_MISC) begin
                dec.acc_write = !dec.dest_reg;
                dec.reg_write = dec.dest_reg;
            end else begin
                dec.reg_write = dec.dest_reg;
            end
            dec.is_cond = (i_instr_word[ifd_pkg::OP4_HI:ifd_pkg::OP4_LO] == ifd_pkg::OP_DECFSZ)
                       || (i_instr_word[ifd_pkg::OP4_HI:ifd_pkg::OP4_LO] == ifd_pkg::OP_INCFSZ);
        end else if (dec.cls == ifd_pkg::IFD_BIT_OPS) begin
            dec.bit_op = i_instr_word[ifd_pkg::BITOP_HI:ifd_pkg::BITOP_LO];
            dec.reg_write = (dec.bit_op == ifd_pkg::BITOP_CLR)
                         || (dec.bit_op == ifd_pkg::BITOP_SET);
            dec.is_cond = (dec.bit_op == ifd_pkg::BITOP_SKL)
                       || (dec.bit_op == ifd_pkg::BITOP_SKH);
        end else if (cls_bits == ifd_pkg::CLS_JUMP) begin
            dec.is_jump = 1'b1;
        end else begin
            // Literal returns ignore the low two bits of the opcode nibble.
            dec.is_ret = (i_instr_word[ifd_pkg::BITOP_HI:ifd_pkg::BITOP_LO]
                          == ifd_pkg::LIT_RET[3:2]);
            dec.acc_write = 1'b1;
        end
    end

    assign two_cycle = fields.is_jump || fields.is_ret || (fields.is_cond && i_test_true);

    always_comb begin
        next_state  = state;
        next_fields = fields;
        if (cycle_end) begin
            case (state)
                IFD_EXEC: begin
                    if (two_cycle) begin
                        next_state  = IFD_FLUSH;
                        next_fields = '0;
                        next_fields.idle_op = 1'b1;
                    end else begin
                        next_fields = dec;
                    end
                end
                IFD_FLUSH: begin
                    next_state  = IFD_EXEC;
                    next_fields = dec;
                end
                default: begin
                    next_state = IFD_EXEC;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state  <= IFD_EXEC;
            fields <= '0;
        end else begin
            state  <= next_state;
            fields <= next_fields;
        end
    end

    assign o_fields      = fields;
    assign o_flush_cycle = (state == IFD_FLUSH);
    assign o_cycle_end   = cycle_end;
    assign o_fetch       = cycle_end && !(state == IFD_EXEC && two_cycle);

    a_acc_keeps_reg: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        fields.acc_write |-> !fields.reg_write)
        else $error("accumulator result also writes register");

    a_flush_is_idle: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (cycle_end && state == IFD_EXEC && two_cycle) |=> o_flush_cycle [*4] ##1 !o_flush_cycle)
        else $error("second cycle not one idle instruction cycle");

    a_flush_fields_idle: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_flush_cycle |-> (fields.idle_op && !fields.reg_write && !fields.acc_write))
        else $error("flush cycle is not idle");

    a_single_cycle: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (cycle_end && state == IFD_EXEC && !two_cycle) |=> !o_flush_cycle [*4])
        else $error("single cycle instruction stretched");

    a_wdt_one_cycle: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        fields.watchdog_clear_op |-> !two_cycle)
        else $error("watchdog clear takes two cycles");

    a_class_matches: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (cycle_end && state == IFD_FLUSH) |=>
            (fields.cls == ifd_pkg::IFD_BIT_OPS) == ($past(cls_bits) == ifd_pkg::CLS_BIT))
        else $error("class does not match top bits");

    a_dest_select: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (fields.cls == ifd_pkg::IFD_BYTE_OPS && fields.acc_write) |-> !fields.dest_reg)
        else $error("target 1 sent result to accumulator");

    a_bit_mask_one: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        $onehot(fields.bit_mask) || fields == '0 || o_flush_cycle)
        else $error("bit mask not a single bit");

    a_fetch_at_end: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_fetch |-> cycle_end)
        else $error("word taken away from the cycle end");

    a_flush_ends_fetch: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (cycle_end && o_flush_cycle) |-> o_fetch)
        else $error("no word taken after the idle cycle");

    // Fields may only move on the edge that closes an instruction cycle.
    a_fields_stand: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        !cycle_end |=> $stable(fields))
        else $error("decoded fields changed inside a cycle");

    a_slot_from_word: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (cycle_end && o_fetch) |=>
            (fields.reg_slot == $past(i_instr_word[ifd_pkg::SLOT_W-1:0])))
        else $error("register slot not taken from the low word bits");

    a_lit_from_word: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (cycle_end && o_fetch) |=>
            (fields.lit8 == $past(i_instr_word[ifd_pkg::LIT8_W-1:0]))
            && (fields.lit11 == $past(i_instr_word[ifd_pkg::LIT11_W-1:0])))
        else $error("literal field not taken from the word");

    a_class_legal: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        fields.cls inside {ifd_pkg::IFD_BYTE_OPS, ifd_pkg::IFD_BIT_OPS, ifd_pkg::IFD_LIT_CTRL})
        else $error("decoded class outside the three classes");

    a_byte_dest: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (fields.cls == ifd_pkg::IFD_BYTE_OPS
            && fields.opcode[ifd_pkg::OP4_HI-ifd_pkg::OP4_LO:0] != ifd_pkg::OP_MISC) |->
            (fields.reg_write == fields.dest_reg) && (fields.acc_write == !fields.dest_reg))
        else $error("byte result target does not follow the target bit");

    a_bit_write_test: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (fields.cls == ifd_pkg::IFD_BIT_OPS) |-> (fields.reg_write != fields.is_cond))
        else $error("bit operation neither writes nor tests");

    a_idle_no_effect: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        fields.idle_op |-> !fields.reg_write && !fields.acc_write && !two_cycle)
        else $error("idle word has an effect");

endmodule // ifd_decoder

// *** verif/ifd_prog_mem.sv ***
// Program memory model that hands the decoder one instruction word per fetch.
`timescale 1ns/1ns
module ifd_prog_mem (
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    // Fetch strobe from the decoder
    input  wire logic        i_fetch,
    // Word at the current fetch address
    output logic [13:0]      o_word
);
    logic [13:0] rom [16];
    logic [3:0]  ptr;
    logic [3:0]  next_ptr;

    // The pointer only moves after a taken fetch, so a refused word is offered again.
    always_comb begin
        next_ptr = (i_fetch === 1'b1) ? ptr + 4'h1 : ptr;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ptr <= 4'h0;
        end else begin
            ptr <= next_ptr;
        end
    end

    assign o_word = rom[ptr];
endmodule // ifd_prog_mem

// *** verif/test_instruction_format_decode.sv ***
// Testbench for the instruction format decoder fed by a program memory model.
`timescale 1ns/1ns
module test_instruction_format_decode;
    logic                 i_core_clk  = 1'b0;
    logic                 i_rst_n     = 1'b0;
    logic                 i_test_true = 1'b0;
    logic [13:0]          word;
    ifd_pkg::ifd_fields_t fld;
    logic                 flush;
    logic                 cyc_end;
    logic                 fetch;
    logic [1:0]           phase;
    logic                 saw_flush;
    int                   fail_count = 0;
    int                   n_compared = 0;
    int                   ticks      = 0;
    int                   n;
    logic [13:0]          prog [16] = '{14'h0063, 14'h077f, 14'h0780, 14'h102a, 14'h15aa,
        14'h1b2a, 14'h1caa, 14'h3055, 14'h3355, 14'h2fff, 14'h0b85, 14'h0f85, 14'h0064,
        14'h0060, 14'h37aa, 14'h0008};

    always #5 i_core_clk = ~i_core_clk;

    ifd_decoder dut_u (
        .i_core_clk    (i_core_clk),
        .i_rst_n       (i_rst_n),
        .i_instr_word  (word),
        .i_test_true   (i_test_true),
        .o_fields      (fld),
        .o_flush_cycle (flush),
        .o_phase       (phase),
        .o_cycle_end   (cyc_end),
        .o_fetch       (fetch)
    );

    ifd_prog_mem mem_u (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_fetch    (fetch),
        .o_word     (word)
    );

    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // The whole program needs about a hundred clocks, so this ceiling only trips on a hang.
    always @(posedge i_core_clk) begin
        ticks++;
        if (ticks == 1000) begin
            fail_count++;
            summarize();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_n(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Waits for the next taken word; n counts clocks since the previous one.
    task automatic take();
        n = 0;
        saw_flush = 1'b0;
        while (fetch !== 1'b1 && n < 20) begin
            @(negedge i_core_clk);
            n++;
            if (flush === 1'b1) saw_flush = 1'b1;
        end
        chk({fetch, cyc_end, phase}, 4'hf);
        @(negedge i_core_clk);
        n++;
    endtask

    task automatic test_byte();
        take();
        chk({fld.cls, fld.opcode, fld.reg_slot, fld.dest_reg, fld.acc_write, fld.reg_write},
            {ifd_pkg::IFD_BYTE_OPS, 6'h07, 7'h7f, 3'b010});
        take();
        chk_n(n, 4);
        chk({fld.cls, fld.opcode, fld.reg_slot, fld.dest_reg, fld.acc_write, fld.reg_write},
            {ifd_pkg::IFD_BYTE_OPS, 6'h07, 7'h00, 3'b101});
        $display("test_byte done");
    endtask

    task automatic test_bit();
        logic [2:0] pos;
        for (int op = 0; op < 4; op++) begin
            pos = 3'(op * 3);
            take();
            chk({fld.cls, fld.bit_op, fld.bit_pos, fld.bit_mask, fld.reg_slot},
                {ifd_pkg::IFD_BIT_OPS, 2'(op), pos, 8'h01 << pos, 7'h2a});
            chk_n(n, 4);
        end
        $display("test_bit done");
    endtask

    task automatic test_lit();
        for (int i = 0; i < 2; i++) begin
            take();
            chk({fld.cls, fld.lit8, fld.acc_write}, {ifd_pkg::IFD_LIT_CTRL, 8'h55, 1'b1});
            chk_n(n, 4);
        end
        take();
        chk({fld.cls, fld.lit11, fld.is_jump}, {ifd_pkg::IFD_LIT_CTRL, 11'h7ff, 1'b1});
        take();
        chk_n(n, 8);
        chk(saw_flush, 1'b1);
        $display("test_lit done");
    endtask

    task automatic test_cond();
        chk(fld.is_cond, 1'b1);
        i_test_true = 1'b1;
        take();
        i_test_true = 1'b0;
        chk_n(n, 8);
        chk(saw_flush, 1'b1);
        take();
        chk_n(n, 4);
        chk(saw_flush, 1'b0);
        $display("test_cond done");
    endtask

    task automatic test_wdt();
        chk({fld.watchdog_clear_op, fld.sleep_op, fld.idle_op, fld.reg_write}, 4'b1000);
        take();
        chk_n(n, 4);
        chk(phase, 2'h0);
        chk(fld.idle_op, 1'b1);
        $display("test_wdt done");
    endtask

    task automatic test_ret();
        take();
        chk_n(n, 4);
        chk({fld.cls, fld.lit8, fld.is_ret, fld.acc_write},
            {ifd_pkg::IFD_LIT_CTRL, 8'haa, 2'b11});
        take();
        chk_n(n, 8);
        chk(saw_flush, 1'b1);
        chk({fld.cls, fld.is_ret, fld.acc_write, fld.reg_write},
            {ifd_pkg::IFD_BYTE_OPS, 3'b100});
        take();
        chk_n(n, 8);
        chk({fld.sleep_op, fld.watchdog_clear_op, fld.idle_op, fld.is_ret}, 4'b1000);
        $display("test_ret done");
    endtask

    initial begin
        for (int i = 0; i < 16; i++) mem_u.rom[i] = prog[i];
        repeat (12) @(negedge i_core_clk);
        chk({fld, flush, phase, cyc_end, fetch}, 64'h0);
        i_rst_n = 1'b1;
        take();
        test_byte();
        test_bit();
        test_lit();
        test_cond();
        test_wdt();
        test_ret();
        summarize();
    end
endmodule // test_instruction_format_decode
